// [core/pims_top.v]
// Interrupt enable and latched status registers behind an AHB-Lite slave
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "pims_map.vh"

module pims_top (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Event sources, one-cycle or level, same clock
  input wire cable_test_event,
  input wire mgmt_sync_lost_event,
  input wire negotiation_change_event,
  input wire frame_tester_event,
  input wire page_received_event,
  input wire idle_error_saturate_event,
  input wire mac_buffer_flow_error_event,
  input wire receive_state_change_event,
  input wire link_state_change_event,
  input wire rate_change_event,
  // Interrupt pin
  output wire int_n
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_sync_b;

  // Assert at once, release two edges later so all flops leave together
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_sync_b = rst_sync_q;

  // ----------------------------------------
  // Address phase
  // ----------------------------------------
  wire addr_valid;
  wire hit_mask;
  wire hit_stat;
  wire rd_stat_now;
  wire rd_mask_now;
  wire rd_any_now;
  wire wr_mask_now;

  // Only the low bits decode; the map repeats above them
  assign addr_valid = hsel & hready & (htrans == `PIMS_HTRANS_NONSEQ);
  assign hit_mask = (haddr[`PIMS_ADDR_W-1:0] == `PIMS_MASK_ADDR);
  assign hit_stat = (haddr[`PIMS_ADDR_W-1:0] == `PIMS_STAT_ADDR);
  assign rd_stat_now = addr_valid & ~hwrite & hit_stat;
  assign rd_mask_now = addr_valid & ~hwrite & hit_mask;
  assign rd_any_now = rd_stat_now | rd_mask_now;
  assign wr_mask_now = addr_valid & hwrite & hit_mask;

  // ----------------------------------------
  // Data phase bookkeeping
  // ----------------------------------------
  reg wr_mask_q;

  // Status is read-only; writes to it and unmapped writes are dropped
  always @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      wr_mask_q <= 1'b0;
    end
    else if (hready)
    begin
      wr_mask_q <= wr_mask_now;
    end
  end

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  reg [10:0] mask_q;
  reg [10:0] mask_d;

  // Reserved bits 15..11 are dropped on write
  always @*
  begin
    mask_d = mask_q;
    if (wr_mask_q)
    begin
      mask_d = hwdata[10:0];
    end
  end

  always @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      mask_q <= `PIMS_MASK_RST;
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // Named enables
  // ----------------------------------------
  wire cable_test_event_enable;
  wire mgmt_sync_event_enable;
  wire negotiation_change_enable;
  wire frame_tester_event_enable;
  wire page_received_enable;
  wire idle_error_saturate_enable;
  wire mac_buffer_flow_error_enable;
  wire receive_state_change_enable;
  wire link_state_change_enable;
  wire rate_change_enable;
  wire interrupt_pin_enable;
  wire [`PIMS_NUM_EVT-1:0] evt_enable;

  assign cable_test_event_enable = mask_q[`PIMS_BIT_CABLE];
  assign mgmt_sync_event_enable = mask_q[`PIMS_BIT_SYNC];
  assign negotiation_change_enable = mask_q[`PIMS_BIT_NEG];
  assign frame_tester_event_enable = mask_q[`PIMS_BIT_FRAME];
  assign page_received_enable = mask_q[`PIMS_BIT_PAGE];
  assign idle_error_saturate_enable = mask_q[`PIMS_BIT_IDLE];
  assign mac_buffer_flow_error_enable = mask_q[`PIMS_BIT_FIFO];
  assign receive_state_change_enable = mask_q[`PIMS_BIT_RECV];
  assign link_state_change_enable = mask_q[`PIMS_BIT_LINK];
  assign rate_change_enable = mask_q[`PIMS_BIT_RATE];
  assign interrupt_pin_enable = mask_q[`PIMS_BIT_PIN];

  // Vector index k holds register bit k+1
  assign evt_enable = {
    cable_test_event_enable,
    mgmt_sync_event_enable,
    negotiation_change_enable,
    frame_tester_event_enable,
    page_received_enable,
    idle_error_saturate_enable,
    mac_buffer_flow_error_enable,
    receive_state_change_enable,
    link_state_change_enable,
    rate_change_enable
  };

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  wire [`PIMS_NUM_EVT-1:0] evt_in;
  wire [`PIMS_NUM_EVT-1:0] flags_q;
  wire [`PIMS_NUM_EVT-1:0] flags_d;
  wire cable_test_event_flag;
  wire mgmt_sync_lost_flag;
  wire negotiation_change_flag;
  wire frame_tester_event_flag;
  wire page_received_flag;
  wire idle_error_saturate_flag;
  wire mac_buffer_flow_error_flag;
  wire receive_state_change_flag;
  wire link_state_change_flag;
  wire rate_change_flag;

  // Raw events feed the flags; the enables play no part here
  assign evt_in = {
    cable_test_event,
    mgmt_sync_lost_event,
    negotiation_change_event,
    frame_tester_event,
    page_received_event,
    idle_error_saturate_event,
    mac_buffer_flow_error_event,
    receive_state_change_event,
    link_state_change_event,
    rate_change_event
  };

  pims_sticky #(
    .WIDTH(`PIMS_NUM_EVT)
  ) u_flags (
    .core_clk(core_clk),
    .rst_sync_b(rst_sync_b),
    .set_i(evt_in),
    .clear_all(rd_stat_now),
    .flags_q(flags_q),
    .flags_d(flags_d)
  );

  // ----------------------------------------
  // Named flags
  // ----------------------------------------
  assign cable_test_event_flag = flags_q[`PIMS_BIT_CABLE-1];
  assign mgmt_sync_lost_flag = flags_q[`PIMS_BIT_SYNC-1];
  assign negotiation_change_flag = flags_q[`PIMS_BIT_NEG-1];
  assign frame_tester_event_flag = flags_q[`PIMS_BIT_FRAME-1];
  assign page_received_flag = flags_q[`PIMS_BIT_PAGE-1];
  assign idle_error_saturate_flag = flags_q[`PIMS_BIT_IDLE-1];
  assign mac_buffer_flow_error_flag = flags_q[`PIMS_BIT_FIFO-1];
  assign receive_state_change_flag = flags_q[`PIMS_BIT_RECV-1];
  assign link_state_change_flag = flags_q[`PIMS_BIT_LINK-1];
  assign rate_change_flag = flags_q[`PIMS_BIT_RATE-1];

  // ----------------------------------------
  // Pending flag
  // ----------------------------------------
  reg pend_q;
  reg pend_d;
  wire [`PIMS_NUM_EVT-1:0] evt_armed;
  wire pend_src;

  // Includes the flags' next value so an event during a read still counts
  assign evt_armed = flags_d & evt_enable;
  assign pend_src = |evt_armed;

  // A status read restarts pending from this cycle's events only
  always @*
  begin
    pend_d = pend_q | pend_src;
    if (rd_stat_now)
    begin
      pend_d = pend_src;
    end
  end

  always @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      pend_q <= `PIMS_PEND_RST;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  reg int_n_q;

  // Registered so decode glitches never reach the pin
  always @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      int_n_q <= 1'b1;
    end
    else
    begin
      // Follows pend_d so the pin moves with the pending bit
      int_n_q <= ~(pend_d & mask_d[`PIMS_BIT_PIN]);
    end
  end

  assign int_n = int_n_q;

  // ----------------------------------------
  // Status view
  // ----------------------------------------
  wire [15:0] stat_view;

  // Reserved bits are not stored and read as zero
  assign stat_view = {
    5'h0,
    cable_test_event_flag,
    mgmt_sync_lost_flag,
    negotiation_change_flag,
    frame_tester_event_flag,
    page_received_flag,
    idle_error_saturate_flag,
    mac_buffer_flow_error_flag,
    receive_state_change_flag,
    link_state_change_flag,
    rate_change_flag,
    pend_q
  };

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  wire [10:0] mask_view;

  // A mask write in its data phase is forwarded to a read behind it
  assign mask_view = wr_mask_q ? hwdata[10:0] : mask_q;

  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (rd_mask_now)
    begin
      rdata_d = {21'h0, mask_view};
    end
    else if (rd_stat_now)
    begin
      rdata_d = {16'h0000, stat_view};
    end
  end

  always @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (hready)
    begin
      rdata_q <= rd_any_now ? rdata_d : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Zero wait states, always OKAY; hsize is not checked
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = `PIMS_HRESP_OKAY;

endmodule

`default_nettype wire

// [core/pims_map.vh]
// Register map, field positions and reset values of the interrupt block
`ifndef PIMS_MAP_VH
`define PIMS_MAP_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define PIMS_MASK_IDX 8'h18
`define PIMS_STAT_IDX 8'h19
`define PIMS_MASK_ADDR 10'h060
`define PIMS_STAT_ADDR 10'h064
`define PIMS_ADDR_W 10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PIMS_MASK_RST 11'h000
`define PIMS_STAT_RST 10'h000
`define PIMS_PEND_RST 1'h0

// ----------------------------------------
// Field positions, shared by both registers
// ----------------------------------------
`define PIMS_BIT_CABLE 10
`define PIMS_BIT_SYNC 9
`define PIMS_BIT_NEG 8
`define PIMS_BIT_FRAME 7
`define PIMS_BIT_PAGE 6
`define PIMS_BIT_IDLE 5
`define PIMS_BIT_FIFO 4
`define PIMS_BIT_RECV 3
`define PIMS_BIT_LINK 2
`define PIMS_BIT_RATE 1
`define PIMS_BIT_PIN 0
`define PIMS_BIT_PEND 0
`define PIMS_NUM_EVT 10

// ----------------------------------------
// Bus encodings
// ----------------------------------------
`define PIMS_HTRANS_NONSEQ 2'h2
`define PIMS_HRESP_OKAY 1'h0

`endif

// [core/pims_sticky.v]
// Bank of sticky event flags with clear-all and set priority
`timescale 1ns/10ps
`default_nettype none

module pims_sticky #(
  parameter WIDTH = 10
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_sync_b,
  // Control
  input wire [WIDTH-1:0] set_i,
  input wire clear_all,
  // State
  output wire [WIDTH-1:0] flags_q,
  output wire [WIDTH-1:0] flags_d
);

  reg [WIDTH-1:0] flag_q;

  // An event in the clearing cycle survives the clear
  assign flags_d = clear_all ? set_i : (flag_q | set_i);
  assign flags_q = flag_q;

  always @(posedge core_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      flag_q <= {WIDTH{1'b0}};
    end
    else
    begin
      flag_q <= flags_d;
    end
  end

endmodule

`default_nettype wire

// [verif/pims_top_sva.sv]
// Checker for the interrupt block bus and pin
`timescale 1ns/10ps
`default_nettype none
`include "pims_map.vh"
module pims_top_sva (
  // Clock, reset and bus
  input wire logic core_clk, rst_b, hsel, hready, hwrite, hreadyout, hresp,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // Events and pin
  input wire logic cable_test_event, mgmt_sync_lost_event,
  input wire logic negotiation_change_event, frame_tester_event,
  input wire logic page_received_event, idle_error_saturate_event,
  input wire logic mac_buffer_flow_error_event, receive_state_change_event,
  input wire logic link_state_change_event, rate_change_event, int_n
);
  wire [9:0] ev = {cable_test_event, mgmt_sync_lost_event,
    negotiation_change_event, frame_tester_event, page_received_event,
    idle_error_saturate_event, mac_buffer_flow_error_event,
    receive_state_change_event, link_state_change_event, rate_change_event};
  wire tk = hsel && hready && htrans == 2'h2;
  wire rd_s = tk && !hwrite && haddr[9:0] == `PIMS_STAT_ADDR;
  logic wp_q, rdp_q;
  logic [9:0] ra_q, since_q, want_q;
  logic [10:0] mask_q;
  // Shadow of the mask and of events seen since the last status read
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      wp_q <= 1'b0;
      rdp_q <= 1'b0;
      ra_q <= 10'h0;
      mask_q <= 11'h0;
      since_q <= 10'h0;
      want_q <= 10'h0;
    end
    else
    begin
      wp_q <= tk && hwrite && haddr[9:0] == `PIMS_MASK_ADDR;
      if (wp_q)
        mask_q <= hwdata[10:0];
      rdp_q <= tk && !hwrite;
      ra_q <= haddr[9:0];
      // Events at a read's own edge belong to the next read
      if (rd_s)
        want_q <= since_q;
      since_q <= rd_s ? ev : since_q | ev;
    end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_upper_zero: assert property (hrdata[31:11] == 21'h0)
    else $error("reserved read bits not zero");
  a_idle_data: assert property (!rdp_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_mask_read: assert property (rdp_q && ra_q == `PIMS_MASK_ADDR
    |-> hrdata[10:0] == mask_q) else $error("mask read mismatch");
  a_unmapped_zero: assert property (rdp_q && ra_q != `PIMS_MASK_ADDR
    && ra_q != `PIMS_STAT_ADDR |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_flag_sticky: assert property (rdp_q && ra_q == `PIMS_STAT_ADDR
    |-> (hrdata[10:1] & want_q) == want_q) else $error("flag lost");
  a_read_clear: assert property (rdp_q && ra_q == `PIMS_STAT_ADDR
    |-> (hrdata[10:1] & ~want_q) == 10'h0)
    else $error("flag not cleared by read");
  a_pin_assert: assert property (!wp_q && mask_q[0]
    && |(ev & mask_q[10:1]) |=> !int_n) else $error("pin not asserted");
  a_pin_masked: assert property (!wp_q && !mask_q[0] |=> int_n)
    else $error("pin asserted while disabled");
  a_pin_clear: assert property (rd_s && !wp_q && ev == 10'h0
    |=> int_n) else $error("pin held after status read");
  a_pin_quiet: assert property (!wp_q && !$past(wp_q)
    && (ev & mask_q[10:1]) == 10'h0 |=> !$fell(int_n))
    else $error("pin fell without enabled event");
endmodule
bind pims_top pims_top_sva chk (.core_clk, .rst_b, .hsel, .hready, .hwrite,
  .hreadyout, .hresp, .htrans, .haddr, .hwdata, .hrdata, .cable_test_event,
  .mgmt_sync_lost_event, .negotiation_change_event, .frame_tester_event,
  .page_received_event, .idle_error_saturate_event, .int_n,
  .mac_buffer_flow_error_event, .receive_state_change_event,
  .link_state_change_event, .rate_change_event);
`default_nettype wire

// [verif/pims_host.sv]
// Bus master model standing in for the management host
`timescale 1ns/10ps
`default_nettype none
module pims_host (
  // Clock and answer
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request
  output logic hsel,
  output logic hwrite,
  output logic [1:0] htrans,
  output logic [2:0] hsize,
  output logic [31:0] haddr,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
  end
  // Unused fields toggle so a stale value never passes for a live one
  task automatic xfer(input logic w, input logic [31:0] a, d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : ~d;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
endmodule
`default_nettype wire

// [verif/pims_top_tb.sv]
// Self-checking bench for the interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "pims_map.vh"
module pims_top_tb;
  localparam logic [31:0] MA = {22'h0, `PIMS_MASK_ADDR};
  localparam logic [31:0] SA = {22'h0, `PIMS_STAT_ADDR};
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] ev = 10'h0;
  logic [31:0] seed = 32'h95de;
  logic [31:0] r;
  wire hsel, hwrite, hreadyout, hresp, int_n;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata;
  int num_errors = 0;
  int comparisons = 0;
  int m_mask, m_fl, m_pd, m_exp, m_wp, i;
  always #5 core_clk = ~core_clk;
  pims_host host (.core_clk, .hready(hreadyout), .hrdata, .hsel, .hwrite,
    .htrans, .hsize, .haddr, .hwdata);
  pims_top dut (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .int_n,
    .cable_test_event(ev[9]), .mgmt_sync_lost_event(ev[8]),
    .negotiation_change_event(ev[7]), .frame_tester_event(ev[6]),
    .page_received_event(ev[5]), .idle_error_saturate_event(ev[4]),
    .mac_buffer_flow_error_event(ev[3]), .receive_state_change_event(ev[2]),
    .link_state_change_event(ev[1]), .rate_change_event(ev[0]));
  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (m_wp != 0)
      m_mask = hwdata[10:0];
    m_wp = hsel && htrans == 2'h2 && hwrite && haddr == MA;
    if (hsel && htrans == 2'h2 && !hwrite)
    begin
      m_exp = haddr == MA ? m_mask : haddr == SA ? m_fl * 2 + m_pd : 0;
      if (haddr == SA)
        m_fl = 0;
      if (haddr == SA)
        m_pd = 0;
    end
    m_fl = m_fl | ev;
    if ((m_fl & (m_mask >> 1)) != 0)
      m_pd = 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk_reg(input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED hrdata exp %h seen %h", exp, got);
    end
  endtask
  // Sampled mid-cycle so model and design have both settled
  task automatic chk_pin();
    logic e;
    @(negedge core_clk);
    e = !(m_pd != 0 && m_mask[0]);
    comparisons++;
    if (int_n !== e)
    begin
      num_errors++;
      $display("CHECK FAILED int_n exp %b seen %b", e, int_n);
    end
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [31:0] a);
    host.xfer(1'b0, a, 32'h0, r);
    chk_reg(m_exp, r);
  endtask
  task automatic wr(input logic [31:0] a, d);
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(MA);
    rd(SA);
    chk_pin();
    $display("reset test done");
    for (i = 0; i < 20; i++)
    begin
      wr(MA, ((i % 2) << (i / 2 + 1)) | 1);
      ev <= 10'(1 << (i / 2));
      @(posedge core_clk);
      ev <= 10'h0;
      chk_pin();
      rd(SA);
      chk_pin();
      rd(SA);
    end
    $display("per event test done");
    for (i = 0; i < 30; i++)
    begin
      seed = xs(seed);
      wr(MA, seed);
      rd(MA);
      seed = xs(seed);
      ev <= seed[9:0];
      @(posedge core_clk);
      ev <= seed[19:10] & seed[29:20];
      @(posedge core_clk);
      ev <= 10'h0;
      chk_pin();
      rd(SA);
    end
    wr(SA, 32'hffff);
    rd(SA);
    rd(32'h68);
    $display("random test done");
    give_verdict();
  end
endmodule
`default_nettype wire
